// [design/fcp_pkg.sv]
// Shared constants and types for the flag offset programming block
package fcp_pkg;

  // ----------------------------------------------------------------
  // Sizes and layout
  // ----------------------------------------------------------------
  localparam int OFS_W       = 15;           // Offset bits at the deepest option
  localparam int DATA_W      = 36;           // Widest data bus
  localparam int LANES_WIDE  = 16;           // Offset bits per transfer on x36/x18
  localparam int LANES_X9    = 8;            // Offset bits per transfer on x9
  localparam int PARITY_LINE = 8;            // Ninth data line, skipped with interspersed parity
  localparam logic [1:0] PTR_FIRST     = 2'h0;
  localparam logic [1:0] PTR_LAST_X36  = 2'h1;  // Two transfers: empty, full
  localparam logic [1:0] PTR_LAST_NARR = 2'h3;  // Four transfers: two parts of each
  localparam logic [OFS_W-1:0] OFS_RESET = 15'h007f;  // Default offset after master reset

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCP_BW36 = 2'h0,
    FCP_BW18 = 2'h1,
    FCP_BW9  = 2'h2
  } fcp_bw_e;

  // Host strobes, all active low except the serial data bit
  typedef struct packed {
    logic offset_load_select_n;
    logic serial_program_enable_n;
    logic write_enable_n;
    logic read_enable_n;
    logic serial_data;
  } fcp_ctl_s;

  // Straps caught while master reset is held
  typedef struct packed {
    logic    serial_mode;
    fcp_bw_e bus_width;
    logic    interspersed;
  } fcp_strap_s;

endpackage

// [design/fcp_serial_cnt.sv]
// Serial bit counter that walks both offset registers in one sequence
`timescale 1ns/1ps
`default_nettype none

module fcp_serial_cnt #(
  parameter int LEN   = 30,
  parameter int CNT_W = $clog2(LEN)
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Control
  input  wire logic             clear,
  input  wire logic             step,
  // State
  output logic [CNT_W-1:0]      count,
  output logic                  at_last
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LEN - 1);

  logic [CNT_W-1:0] count_ff;

  // Bit index; wraps so a new sequence always restarts at the empty LSB
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (clear) begin
      count_ff <= '0;                                    // [RULE17]
    end else if (step) begin
      count_ff <= (count_ff == LAST) ? '0 : count_ff + 1'b1;  // [RULE6] [RULE8]
    end
  end

  assign count   = count_ff;
  assign at_last = (count_ff == LAST);                    // [RULE17]

endmodule // fcp_serial_cnt

`default_nettype wire

// [design/fcp_offset_regs.sv]
// Programmable flag offset registers with serial and parallel load paths
// Notes on behaviour
// RULE1 - Both selects low: one serial bit per edge
// RULE2 - Serial order: empty LSB first, full MSB last
// RULE3 - Host shifts twice the offset width per sequence
// RULE4 - Offset width set by depth, 10 to 15
// RULE5 - Lines past significant bits ignored on write
// RULE6 - Serial load always covers both registers
// RULE7 - Flags invalid until serial sequence completes
// RULE8 - Serial reprogramming allowed any number of times
// RULE9 - Select low, enable high: no serial write
// RULE10 - x36: empty then full, whole each
// RULE11 - Interspersed parity skips ninth line, shifts upper bits
// RULE12 - x18: lower empty part first, same placement
// RULE13 - x9: two byte parts per register, low first
// RULE14 - Parallel writes walk parts, wrap to empty
// RULE15 - Separate pointers, master reset clears both
// RULE16 - Host may pause serial load, resumes in sequence
// RULE17 - Internal bit counter selects bit, flags completion
`timescale 1ns/1ps
`default_nettype none

module fcp_offset_regs #(
  parameter int               OFS_W     = fcp_pkg::OFS_W,   // [RULE4]
  parameter int               DATA_W    = fcp_pkg::DATA_W,
  parameter logic [OFS_W-1:0] OFS_RESET = fcp_pkg::OFS_RESET
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Pins from the host
  input  wire logic                master_reset_n,
  input  wire fcp_pkg::fcp_strap_s straps,
  input  wire fcp_pkg::fcp_ctl_s   pins,
  input  wire logic [DATA_W-1:0]   input_word,
  // Register contents and status
  output logic [DATA_W-1:0]        output_word,
  output logic [OFS_W-1:0]         empty_side_offset,
  output logic [OFS_W-1:0]         full_side_offset,
  output logic                     offsets_valid,
  output logic                     serial_mode
);
  import fcp_pkg::*;

  localparam int SER_LEN = 2 * OFS_W;                        // [RULE3]
  localparam int CNT_W   = $clog2(SER_LEN);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Data line for offset bit k of one part; parity line skipped on wide buses with interspersed parity
  function automatic int line_of(input int k, input logic isp, input fcp_bw_e bw);
    line_of = (isp && bw != FCP_BW9 && k >= PARITY_LINE) ? k + 1 : k;  // [RULE11]
  endfunction

  function automatic int lanes_of(input fcp_bw_e bw);
    lanes_of = (bw == FCP_BW9) ? LANES_X9 : LANES_WIDE;     // [RULE13]
  endfunction

  // Merge one transfer into a register; lines past the offset are dropped
  function automatic logic [OFS_W-1:0] unpack(input logic [OFS_W-1:0] cur, input logic [DATA_W-1:0] w,
                                               input logic part, input fcp_bw_e bw, input logic isp);
    int k;
    unpack = cur;
    for (int b = 0; b < OFS_W; b++) begin
      k = b - (part ? lanes_of(bw) : 0);
      if (k >= 0 && k < lanes_of(bw)) begin
        unpack[b] = w[line_of(k, isp, bw)];                   // [RULE5] [RULE12]
      end
    end
  endfunction

  // Place one part of a register on the data lines, unused lines low
  function automatic logic [DATA_W-1:0] pack(input logic [OFS_W-1:0] v, input logic part,
                                             input fcp_bw_e bw, input logic isp);
    int k;
    pack = '0;
    for (int b = 0; b < OFS_W; b++) begin
      k = b - (part ? lanes_of(bw) : 0);
      if (k >= 0 && k < lanes_of(bw)) begin
        pack[line_of(k, isp, bw)] = v[b];                     // [RULE10] [RULE12] [RULE13]
      end
    end
  endfunction

  function automatic logic [1:0] ptr_last(input fcp_bw_e bw);
    ptr_last = (bw == FCP_BW36) ? PTR_LAST_X36 : PTR_LAST_NARR;
  endfunction

  function automatic logic [1:0] ptr_next(input logic [1:0] p, input fcp_bw_e bw);
    ptr_next = (p == ptr_last(bw)) ? PTR_FIRST : p + 2'h1;   // [RULE14]
  endfunction

  // Register select (0 empty, 1 full) and part select for a pointer value
  function automatic logic ptr_reg(input logic [1:0] p, input fcp_bw_e bw);
    ptr_reg = (bw == FCP_BW36) ? p[0] : p[1];
  endfunction

  function automatic logic ptr_part(input logic [1:0] p, input fcp_bw_e bw);
    ptr_part = (bw == FCP_BW36) ? 1'b0 : p[0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fcp_ctl_s          ctl_meta_ff,  ctl_ff;
  fcp_strap_s        strap_meta_ff, strap_sync_ff;
  logic              mr_meta_ff,   mr_ff;
  logic [DATA_W-1:0] word_meta_ff, word_ff;

  // Two stages on every pin; only the second stage feeds logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_meta_ff   <= '1;
      ctl_ff        <= '1;
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
      mr_meta_ff    <= 1'b0;
      mr_ff         <= 1'b0;
      word_meta_ff  <= '0;
      word_ff       <= '0;
    end else begin
      ctl_meta_ff   <= pins;
      ctl_ff        <= ctl_meta_ff;
      strap_meta_ff <= straps;
      strap_sync_ff <= strap_meta_ff;
      mr_meta_ff    <= master_reset_n;
      mr_ff         <= mr_meta_ff;
      word_meta_ff  <= input_word;
      word_ff       <= word_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Mode straps, caught only during master reset
  // ----------------------------------------------------------------
  fcp_strap_s strap_ff;
  logic       mr_active;

  assign mr_active = !mr_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_ff <= '0;
    end else if (mr_active) begin
      strap_ff <= strap_sync_ff;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic ser_step;
  logic par_wr;
  logic par_rd;

  // A pause on either select simply holds the counter in place
  assign ser_step = !mr_active && strap_ff.serial_mode && !ctl_ff.offset_load_select_n
                    && !ctl_ff.serial_program_enable_n;         // [RULE1] [RULE9] [RULE16]
  assign par_wr   = !mr_active && !strap_ff.serial_mode && !ctl_ff.offset_load_select_n
                    && !ctl_ff.write_enable_n;                  // [RULE14]
  // Reads are open in either programming method
  assign par_rd   = !mr_active && !ctl_ff.offset_load_select_n && !ctl_ff.read_enable_n;

  // ----------------------------------------------------------------
  // Serial bit counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] ser_cnt;
  logic             ser_last;

  fcp_serial_cnt #(
    .LEN   (SER_LEN),
    .CNT_W (CNT_W)
  ) u_serial_cnt (
    .clock   (clock),
    .rst     (rst),
    .clear   (mr_active),
    .step    (ser_step),
    .count   (ser_cnt),
    .at_last (ser_last)
  );

  // ----------------------------------------------------------------
  // Offset pointers
  // ----------------------------------------------------------------
  logic [1:0] wr_ptr_ff;
  logic [1:0] rd_ptr_ff;

  // Partial reset has no path here, so it cannot move either pointer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= PTR_FIRST;
    end else if (mr_active) begin
      wr_ptr_ff <= PTR_FIRST;                                  // [RULE15]
    end else if (par_wr) begin
      wr_ptr_ff <= ptr_next(wr_ptr_ff, strap_ff.bus_width);    // [RULE14]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_ptr_ff <= PTR_FIRST;
    end else if (mr_active) begin
      rd_ptr_ff <= PTR_FIRST;                                  // [RULE15]
    end else if (par_rd) begin
      rd_ptr_ff <= ptr_next(rd_ptr_ff, strap_ff.bus_width);
    end
  end

  // ----------------------------------------------------------------
  // Offset storage: {full, empty}
  // ----------------------------------------------------------------
  logic [2*OFS_W-1:0] ofs_ff;
  logic               wsel;

  assign wsel = ptr_reg(wr_ptr_ff, strap_ff.bus_width);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ofs_ff <= {OFS_RESET, OFS_RESET};
    end else if (mr_active) begin
      ofs_ff <= {OFS_RESET, OFS_RESET};
    end else if (ser_step) begin
      ofs_ff[ser_cnt] <= ctl_ff.serial_data;                   // [RULE1] [RULE2]
    end else if (par_wr && wsel) begin
      ofs_ff[2*OFS_W-1:OFS_W] <= unpack(ofs_ff[2*OFS_W-1:OFS_W], word_ff,
                                        ptr_part(wr_ptr_ff, strap_ff.bus_width),
                                        strap_ff.bus_width, strap_ff.interspersed);
    end else if (par_wr) begin
      ofs_ff[OFS_W-1:0] <= unpack(ofs_ff[OFS_W-1:0], word_ff,
                                  ptr_part(wr_ptr_ff, strap_ff.bus_width),
                                  strap_ff.bus_width, strap_ff.interspersed);
    end
  end

  // Flags are untrustworthy from the first loaded bit until the set is whole
  logic valid_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valid_ff <= 1'b1;
    end else if (mr_active) begin
      valid_ff <= 1'b1;
    end else if (ser_step) begin
      valid_ff <= ser_last;                                    // [RULE7]
    end else if (par_wr) begin
      valid_ff <= (wr_ptr_ff == ptr_last(strap_ff.bus_width));
    end
  end

  // ----------------------------------------------------------------
  // Parallel read; overwrites whatever word stood on the output
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] out_ff;
  logic [OFS_W-1:0]  rd_val;

  assign rd_val = ptr_reg(rd_ptr_ff, strap_ff.bus_width) ? ofs_ff[2*OFS_W-1:OFS_W] : ofs_ff[OFS_W-1:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_ff <= '0;
    end else if (par_rd) begin
      out_ff <= pack(rd_val, ptr_part(rd_ptr_ff, strap_ff.bus_width),
                     strap_ff.bus_width, strap_ff.interspersed);  // [RULE10] [RULE11]
    end
  end

  assign output_word       = out_ff;
  assign empty_side_offset = ofs_ff[OFS_W-1:0];
  assign full_side_offset  = ofs_ff[2*OFS_W-1:OFS_W];
  assign offsets_valid     = valid_ff;
  assign serial_mode       = strap_ff.serial_mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_ser_capture;
    ser_step |=> ofs_ff[$past(ser_cnt)] == $past(ctl_ff.serial_data);
  endproperty
  a_ser_capture: assert property (p_ser_capture) else $error("serial bit not captured"); // [RULE1]

  property p_ser_order;
    ser_step && ser_last |=> full_side_offset[OFS_W-1] == $past(ctl_ff.serial_data) && ser_cnt == '0;
  endproperty
  a_ser_order: assert property (p_ser_order) else $error("last serial bit misplaced"); // [RULE2]

  property p_ser_both;
    ser_step && ser_cnt == CNT_W'(OFS_W - 1) |=> !valid_ff && ser_cnt == CNT_W'(OFS_W);
  endproperty
  a_ser_both: assert property (p_ser_both) else $error("serial load stopped after empty"); // [RULE6]

  property p_ser_invalid;
    ser_step && !ser_last |=> !offsets_valid;
  endproperty
  a_ser_invalid: assert property (p_ser_invalid) else $error("flags valid mid sequence"); // [RULE7]

  property p_ser_done;
    ser_step && ser_last |=> offsets_valid;
  endproperty
  a_ser_done: assert property (p_ser_done) else $error("flags not valid after load"); // [RULE17]

  property p_ser_hold;
    strap_ff.serial_mode && !ctl_ff.offset_load_select_n && ctl_ff.serial_program_enable_n && !mr_active
      |=> $stable(ofs_ff) && $stable(ser_cnt);
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("serial write while disabled"); // [RULE9]

  property p_wr_wrap;
    par_wr && wr_ptr_ff == ptr_last(strap_ff.bus_width) |=> wr_ptr_ff == PTR_FIRST;
  endproperty
  a_wr_wrap: assert property (p_wr_wrap) else $error("write pointer did not wrap"); // [RULE14]

  property p_mr_ptrs;
    mr_active |=> wr_ptr_ff == PTR_FIRST && rd_ptr_ff == PTR_FIRST && ser_cnt == '0;
  endproperty
  a_mr_ptrs: assert property (p_mr_ptrs) else $error("pointers not cleared"); // [RULE15]

  property p_rd_x36;
    par_rd && strap_ff.bus_width == FCP_BW36 && !strap_ff.interspersed && rd_ptr_ff == PTR_FIRST
      |=> output_word[OFS_W-1:0] == $past(empty_side_offset);
  endproperty
  a_rd_x36: assert property (p_rd_x36) else $error("x36 empty read wrong"); // [RULE10]

  property p_rd_parity;
    par_rd && strap_ff.interspersed |=> output_word[PARITY_LINE] == 1'b0;
  endproperty
  a_rd_parity: assert property (p_rd_parity) else $error("ninth line carries offset"); // [RULE11]

  c_ser_full: cover property (ser_step && ser_last);
  c_par_wrap: cover property (par_wr && wr_ptr_ff == PTR_LAST_NARR);
  c_rd_x9:    cover property (par_rd && strap_ff.bus_width == FCP_BW9 && rd_ptr_ff[0]);

endmodule // fcp_offset_regs

`default_nettype wire

// [verification/fcp_host_model.sv]
// Host controller model that drives the offset programming pins
`timescale 1ns/1ps
`default_nettype none

module fcp_host_model (
  // Clock
  input  wire logic                         clock,
  // Pins toward the offset registers
  output var logic                          master_reset_n,
  output var fcp_pkg::fcp_strap_s           straps,
  output var fcp_pkg::fcp_ctl_s             pins,
  output var logic [fcp_pkg::DATA_W-1:0]    input_word
);
  import fcp_pkg::*;

  // ----------------------------------------------------------------
  // Pin drivers, all changed just after a falling edge
  // ----------------------------------------------------------------
  // Start with master reset held and all strobes idle
  initial begin
    master_reset_n = 1'b0;
    straps         = '0;
    pins           = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    input_word     = '0;
  end

  // Idle cycles; released data lines flip so stale values never pass for real ones
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clock);
      pins       = '{1'b1, 1'b1, 1'b1, 1'b1, ~pins.serial_data};
      input_word = ~input_word;
    end
  endtask

  // Straps held stable across the whole master reset pulse
  task automatic mreset(input logic mode, input fcp_bw_e bw, input logic isp);
    @(negedge clock);
    master_reset_n = 1'b0;
    straps         = '{serial_mode: mode, bus_width: bw, interspersed: isp};
    idle(5);
    master_reset_n = 1'b1;
    idle(5);
  endtask

  // One serial bit per edge; test_serial sends the full 2*OFS_W bits, test_par sends only two
  task automatic shift_bit(input logic b);
    @(negedge clock);
    pins = '{1'b0, 1'b0, 1'b1, 1'b1, b};
  endtask

  // Pause by raising one select while the other stays low; via_enable picks the serial enable
  task automatic hold_pause(input int n, input logic via_enable);
    repeat (n) begin
      @(negedge clock);
      pins = '{~via_enable, via_enable, 1'b1, 1'b1, ~pins.serial_data};
    end
  endtask

  // Parallel write of the next register part; back to back allowed
  task automatic par_write(input logic [DATA_W-1:0] w);
    @(negedge clock);
    pins       = '{1'b0, 1'b1, 1'b0, 1'b1, ~pins.serial_data};
    input_word = w;
  endtask

  // Single read strobe, then idle long enough for the answer to land
  task automatic par_read();
    @(negedge clock);
    pins = '{1'b0, 1'b1, 1'b1, 1'b0, ~pins.serial_data};
    idle(5);
  endtask
endmodule // fcp_host_model

`default_nettype wire

// [verification/fcp_offset_regs_bench.sv]
// Self-checking bench for the flag offset registers
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module fcp_offset_regs_bench;
  import fcp_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                   clock;
  logic                   rst;
  wire logic              master_reset_n;
  wire fcp_strap_s        straps;
  wire fcp_ctl_s          pins;
  wire logic [DATA_W-1:0] input_word;
  wire logic [DATA_W-1:0] output_word;
  wire logic [OFS_W-1:0]  empty_side_offset;
  wire logic [OFS_W-1:0]  full_side_offset;
  wire logic              offsets_valid;
  wire logic              serial_mode;
  int                     error_cnt = 0;
  int                     tests_run = 0;

  fcp_host_model i_host (.clock(clock), .master_reset_n(master_reset_n), .straps(straps),
                         .pins(pins), .input_word(input_word));

  fcp_offset_regs i_dut (.clock(clock), .rst(rst), .master_reset_n(master_reset_n), .straps(straps),
                         .pins(pins), .input_word(input_word), .output_word(output_word),
                         .empty_side_offset(empty_side_offset), .full_side_offset(full_side_offset),
                         .offsets_valid(offsets_valid), .serial_mode(serial_mode));

  // Clock at 125 MHz
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Line placement of one register part; unused lines stay zero
  function automatic logic [DATA_W-1:0] fmap(input logic [OFS_W-1:0] v, input fcp_bw_e bw,
                                             input logic isp, input logic hi);
    logic [DATA_W-1:0] w;
    w = '0;
    if (bw == FCP_BW9) begin
      w[7:0] = hi ? {1'b0, v[14:8]} : v[7:0];
    end else if (!hi) begin
      if (isp) begin
        w[7:0]  = v[7:0];
        w[15:9] = v[14:8];
      end else begin
        w[14:0] = v;
      end
    end
    return w;
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Two full serial sequences, each paused both ways partway through
  task automatic test_serial();
    logic [OFS_W-1:0]   ev [2];
    logic [OFS_W-1:0]   fv [2];
    logic [2*OFS_W-1:0] seq;
    ev = '{15'h1a35, 15'h0001};
    fv = '{15'h6c5b, 15'h4000};
    i_host.mreset(1'b1, FCP_BW36, 1'b0);
    `CHECK("serial_mode", 1'b1, serial_mode)
    for (int r = 0; r < 2; r++) begin
      seq = {fv[r], ev[r]};
      for (int i = 0; i < 2 * OFS_W; i++) begin
        i_host.shift_bit(seq[i]);
        if (i == 9) begin
          i_host.hold_pause(4, 1'b1);  // select low, enable high, data toggling: nothing stored
          `CHECK("valid_mid", 1'b0, offsets_valid)
          i_host.hold_pause(3, 1'b0);
        end
      end
      i_host.idle(4);
      `CHECK("ser_empty", ev[r], empty_side_offset)
      `CHECK("ser_full", fv[r], full_side_offset)
      `CHECK("ser_valid", 1'b1, offsets_valid)
    end
    // A parallel write in serial mode must leave the offsets alone
    i_host.par_write('1);
    i_host.idle(4);
    `CHECK("ser_par_refused", ev[1], empty_side_offset)
    `CHECK("ser_par_valid", 1'b1, offsets_valid)
    i_host.par_read();
    `CHECK("ser_read", fmap(ev[1], FCP_BW36, 1'b0, 1'b0), output_word)
    $display("test serial done");
  endtask

  // Full parallel write walk, ignored serial steps, wrap, then read walk
  task automatic test_par(input fcp_bw_e bw, input logic isp);
    logic [OFS_W-1:0]  val [2];
    logic [OFS_W-1:0]  nv;
    logic [DATA_W-1:0] m;
    int                n;
    val = '{15'h2b6d, 15'h51a7};
    nv  = 15'h1c3e;
    n   = (bw == FCP_BW36) ? 2 : 4;
    i_host.mreset(1'b0, bw, isp);
    `CHECK("par_mode", 1'b0, serial_mode)
    `CHECK("rst_empty", OFS_RESET, empty_side_offset)
    for (int p = 0; p < n; p++) begin
      m = fmap(15'h7fff, bw, isp, p[0] && n == 4);
      i_host.par_write(fmap(val[p / (n / 2)], bw, isp, p[0] && n == 4) | ~m);
      if (p == 0) begin
        i_host.idle(4);
        `CHECK("par_valid_mid", 1'b0, offsets_valid)
      end
    end
    i_host.shift_bit(1'b1);
    i_host.shift_bit(1'b0);
    i_host.idle(4);
    `CHECK("par_empty", val[0], empty_side_offset)
    `CHECK("par_full", val[1], full_side_offset)
    `CHECK("par_valid", 1'b1, offsets_valid)
    i_host.par_write(fmap(nv, bw, isp, 1'b0) | ~fmap(15'h7fff, bw, isp, 1'b0));
    i_host.idle(4);
    if (bw == FCP_BW9) nv = {val[0][14:8], nv[7:0]};
    `CHECK("par_wrap", nv, empty_side_offset)
    val[0] = nv;
    for (int p = 0; p < n; p++) begin
      i_host.par_read();
      `CHECK("par_read", fmap(val[p / (n / 2)], bw, isp, p[0] && n == 4), output_word)
    end
    $display("test parallel width %0d interspersed %0d done", bw, isp);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clock);
    `CHECK("rst_empty", OFS_RESET, empty_side_offset)
    `CHECK("rst_full", OFS_RESET, full_side_offset)
    `CHECK("rst_out", 36'h0, output_word)
    `CHECK("rst_valid", 1'b1, offsets_valid)
    @(negedge clock);
    rst = 1'b0;
    $display("test reset done");
    test_serial();
    // Mid-run reset: everything falls back at once, straps keep their reset value until the next master reset
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    `CHECK("rst2_empty", OFS_RESET, empty_side_offset)
    `CHECK("rst2_full", OFS_RESET, full_side_offset)
    `CHECK("rst2_out", 36'h0, output_word)
    `CHECK("rst2_mode", 1'b0, serial_mode)
    @(negedge clock);
    rst = 1'b0;
    test_par(FCP_BW36, 1'b0);
    test_par(FCP_BW36, 1'b1);
    test_par(FCP_BW18, 1'b1);
    test_par(FCP_BW18, 1'b0);
    test_par(FCP_BW9, 1'b0);
    test_par(FCP_BW9, 1'b1);
    complete_run();
  end

  // The whole run needs well under 1500 cycles; this leaves wide margin
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule // fcp_offset_regs_bench

`undef CHECK
`default_nettype wire
